// ==== verilog/mtc_pkg.sv ====
// Constants, codes and types shared by the multi-purpose training command block.
package mtc_pkg;

    // ----------------------------------------------------------------
    // Command/address line encodings
    // ----------------------------------------------------------------
    localparam int CAL_W = 6;                              // Width of the command/address lines.
    localparam logic [4:0] FIRST_EDGE_CODE = 5'h00;         // Lower lines on the first edge of the command.
    localparam logic [4:0] CAS2_FIRST_CODE = 5'h12;         // Lower lines on the first edge of a second-part column command.
    localparam int ARG_TOP_BIT = 5;                         // Line that carries argument bit 6 on the first edge.

    // ----------------------------------------------------------------
    // Argument codes
    // ----------------------------------------------------------------
    localparam logic [6:0] ARG_BUF_READ = 7'h41;            // Training buffer read.
    localparam logic [6:0] ARG_PATTERN_CAL = 7'h43;         // Pattern read calibration.
    localparam logic [6:0] ARG_BUF_WRITE = 7'h47;           // Training buffer write.
    localparam logic [6:0] ARG_OSC_START = 7'h4b;           // Interval oscillator start.
    localparam logic [6:0] ARG_OSC_STOP = 7'h4d;            // Interval oscillator stop.
    localparam logic [6:0] ARG_IMP_START = 7'h4f;           // Impedance calibration start.
    localparam logic [6:0] ARG_IMP_LATCH = 7'h51;           // Impedance calibration latch.

    // ----------------------------------------------------------------
    // Training buffer geometry
    // ----------------------------------------------------------------
    localparam int BURST_LEN = 16;                          // Beats in every training burst.
    localparam int BEAT_W = 4;                              // Width of the beat counter.
    localparam int BUF_ENTRIES = 5;                         // Entries of the training buffer.
    localparam int PTR_W = 3;                               // Width of a buffer pointer.
    localparam logic [PTR_W-1:0] PTR_FIRST = 3'h0;          // First buffer entry.
    localparam logic [PTR_W-1:0] PTR_LAST = 3'h4;           // Last buffer entry before the wrap.
    localparam logic [BEAT_W-1:0] BEAT_LAST = 4'hf;         // Last beat of a burst.
    localparam int PAT_W = 8;                               // Beats taken from each pattern register.
    localparam int MASK_W = 2;                              // Mask/inversion lines.

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MTC_IDLE = 2'b00,
        MTC_ARG = 2'b01,
        MTC_CAS_A = 2'b10,
        MTC_CAS_B = 2'b11
    } mtc_cmd_state_t;

    typedef enum logic [1:0] {
        MTC_XFER_NONE = 2'b00,
        MTC_XFER_WR = 2'b01,
        MTC_XFER_RD = 2'b10,
        MTC_XFER_CAL = 2'b11
    } mtc_xfer_t;

endpackage : mtc_pkg

// ==== verilog/mtc_training_cmd.sv ====
// Decoder for the multi-purpose command with its five-entry training buffer.
// Function
// - Decode seven-bit argument to select operation.
// - Bit 6 low means no operation.
// - Latency counted from column command's second edge.
// - Non-array functions need no column command.
// - Command spans two edges with fixed line use.
// - Decode buffer read, pattern calibration, buffer write.
// - Decode oscillator, impedance codes; others reserved.
// - Training buffer bursts always sixteen beats.
// - Buffer write accepted in any bank state.
// - Back to back buffer writes accepted.
// - Write data captured with write latency.
// - Five entries; sixth write overwrites first.
// - Pointers disturbed; reads follow writes directly.
// - Read pointer wraps after five reads.
// - Read data returned with read latency.
// - Back to back buffer reads serviced.
// - Mask lines driven when any inversion/masking enabled.
`timescale 1ns/10ps
module mtc_training_cmd import mtc_pkg::*; #(
    parameter int DATA_W = 16,                      // Data lines of one beat.
    parameter int LAT_W = 5                         // Width of the latency settings.
) (
    input wire logic clk,                           // 125 MHz clock.
    input wire logic rstn,                          // Asynchronous reset, active low.
    input wire logic cs_pin,                        // Chip select pin.
    input wire logic [CAL_W-1:0] cmd_addr_lines,    // Command/address pins.
    input wire logic cke_pin,                       // Clock enable pin.
    input wire logic ptr_disturb,                   // Pulse: ordinary write, masked write, read or mode read.
    input wire logic [LAT_W-1:0] write_latency,     // Write latency in cycles, at least one.
    input wire logic [LAT_W-1:0] read_latency,      // Read latency in cycles, at least one.
    input wire logic wr_bus_inversion_en,           // Write inversion enabled.
    input wire logic rd_bus_inversion_en,           // Read inversion enabled.
    input wire logic data_masking_en,               // Data masking enabled.
    input wire logic [PAT_W-1:0] pattern_register_low,  // Pattern for beats 0 to 7.
    input wire logic [PAT_W-1:0] pattern_register_high, // Pattern for beats 8 to 15.
    input wire logic [DATA_W-1:0] invert_mask,      // Lanes whose pattern is inverted.
    input wire logic [DATA_W-1:0] wr_beat,          // Write beat from the data receivers.
    input wire logic [MASK_W-1:0] wr_mask,          // Mask lines of the write beat.
    output logic wr_beat_take,                      // High in each cycle a write beat is stored.
    output logic rd_valid,                          // Read beat available.
    input wire logic rd_ready,                      // Receiver takes the read beat.
    output logic [DATA_W-1:0] rd_data,              // Read beat data.
    output logic [MASK_W-1:0] rd_mask,              // Read beat mask lines.
    output logic rd_mask_oe,                        // Drive mask lines with this beat.
    output logic osc_start,                         // Pulse: start interval oscillator.
    output logic osc_stop,                          // Pulse: stop interval oscillator.
    output logic impedance_cal_start,               // Pulse: start impedance calibration.
    output logic impedance_cal_latch,               // Pulse: latch impedance calibration.
    output logic nop_seen,                          // Pulse: no-operation decoded.
    output logic reserved_seen                      // Pulse: reserved code ignored.
);

    localparam int LAT_MAX = 1 << LAT_W;
    localparam int WORD_W = 1 + MASK_W + DATA_W;
    localparam int MEM_W = MASK_W + DATA_W;

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    // Buffer entries are laid out as sixteen words each.
    function automatic logic [PTR_W+BEAT_W-1:0] mem_index(input logic [PTR_W-1:0] entry,
                                                         input logic [BEAT_W-1:0] beat);
        mem_index = {entry, beat};
    endfunction : mem_index

    // Five-entry pointer advance with wrap to the first entry.
    function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] ptr);
        ptr_step = (ptr == PTR_LAST) ? PTR_FIRST : ptr + 3'h1;
    endfunction : ptr_step

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic cs_s1, cs_q, cke_s1, cke_q;
    logic [CAL_W-1:0] cal_s1, cal_q;

    // Pins come from the controller's timing, so each passes two flops.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cs_s1 <= 1'b0;
            cs_q <= 1'b0;
            cke_s1 <= 1'b0;
            cke_q <= 1'b0;
            cal_s1 <= '0;
            cal_q <= '0;
        end else begin
            cs_s1 <= cs_pin;
            cs_q <= cs_s1;
            cke_s1 <= cke_pin;
            cke_q <= cke_s1;
            cal_s1 <= cmd_addr_lines;
            cal_q <= cal_s1;
        end
    end

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    mtc_cmd_state_t state, next_state;
    logic arg_bit6;
    mtc_xfer_t held_type;

    wire first_edge = cs_q && (cal_q[4:0] == FIRST_EDGE_CODE);
    wire cas_first = cs_q && (cal_q[4:0] == CAS2_FIRST_CODE);
    wire second_edge = (state == MTC_ARG) && !cs_q;
    wire [6:0] command_argument_bits = {arg_bit6, cal_q};
    wire dec_rd = second_edge && (command_argument_bits == ARG_BUF_READ);
    wire dec_cal = second_edge && (command_argument_bits == ARG_PATTERN_CAL);
    wire dec_wr = second_edge && (command_argument_bits == ARG_BUF_WRITE);
    wire dec_osc_go = second_edge && (command_argument_bits == ARG_OSC_START);
    wire dec_osc_end = second_edge && (command_argument_bits == ARG_OSC_STOP);
    wire dec_imp_go = second_edge && (command_argument_bits == ARG_IMP_START);
    wire dec_imp_end = second_edge && (command_argument_bits == ARG_IMP_LATCH);
    wire dec_nop = second_edge && !arg_bit6;
    wire dec_array = dec_rd || dec_cal || dec_wr;
    wire dec_other = dec_osc_go || dec_osc_end || dec_imp_go || dec_imp_end;
    wire dec_reserved = second_edge && arg_bit6 && !dec_array && !dec_other;
    wire launch = (state == MTC_CAS_B) && !cs_q;

    // Array functions wait for the column command; the rest finish here.
    always_comb begin
        next_state = state;
        unique case (state)
            MTC_IDLE: begin
                if (first_edge) begin
                    next_state = MTC_ARG;
                end
            end
            MTC_ARG: begin
                if (dec_array) begin
                    next_state = MTC_CAS_A;
                end else begin
                    next_state = MTC_IDLE;
                end
            end
            MTC_CAS_A: begin
                // Anything but the column command drops the training access.
                next_state = cas_first ? MTC_CAS_B : MTC_IDLE;
            end
            MTC_CAS_B: begin
                next_state = MTC_IDLE;
            end
        endcase
    end

    // Bit 6 is caught on the first edge, the function type on the second.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= MTC_IDLE;
            arg_bit6 <= 1'b0;
            held_type <= MTC_XFER_NONE;
        end else begin
            state <= next_state;
            if (state == MTC_IDLE && first_edge) begin
                arg_bit6 <= cal_q[ARG_TOP_BIT];
            end
            if (second_edge) begin
                held_type <= dec_wr ? MTC_XFER_WR : dec_rd ? MTC_XFER_RD : dec_cal ? MTC_XFER_CAL : MTC_XFER_NONE;
            end
        end
    end

    // Function pulses leave from flops one cycle after the second edge.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            osc_start <= 1'b0;
            osc_stop <= 1'b0;
            impedance_cal_start <= 1'b0;
            impedance_cal_latch <= 1'b0;
            nop_seen <= 1'b0;
            reserved_seen <= 1'b0;
        end else begin
            osc_start <= dec_osc_go;
            osc_stop <= dec_osc_end;
            impedance_cal_start <= dec_imp_go;
            impedance_cal_latch <= dec_imp_end;
            nop_seen <= dec_nop;
            reserved_seen <= dec_reserved;
        end
    end

    // ----------------------------------------------------------------
    // Buffer pointers
    // ----------------------------------------------------------------
    logic [PTR_W-1:0] wr_ptr, rd_ptr;
    wire launch_wr = launch && (held_type == MTC_XFER_WR);
    wire launch_rd = launch && (held_type == MTC_XFER_RD);
    wire launch_cal = launch && (held_type == MTC_XFER_CAL);
    // Refresh, bank state and self refresh are not inputs: a write is never refused.
    wire ptr_clear = ptr_disturb || !cke_q || launch_cal;

    // Pointers advance when the access is launched, so seamless commands chain.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr <= PTR_FIRST;
            rd_ptr <= PTR_FIRST;
        end else if (ptr_clear) begin
            wr_ptr <= PTR_FIRST;
            rd_ptr <= PTR_FIRST;
        end else begin
            if (launch_wr) begin
                wr_ptr <= ptr_step(wr_ptr);
            end
            if (launch_rd) begin
                rd_ptr <= ptr_step(rd_ptr);
            end
        end
    end

    // ----------------------------------------------------------------
    // Latency delay line
    // ----------------------------------------------------------------
    logic [1:0] pipe_type [LAT_MAX];
    logic [PTR_W-1:0] pipe_entry [LAT_MAX];
    logic [1:0] next_pipe_type [LAT_MAX];
    logic [PTR_W-1:0] next_pipe_entry [LAT_MAX];
    wire [LAT_W-1:0] lat_sel = launch_wr ? write_latency : read_latency;
    wire [LAT_W-1:0] lat_slot = (lat_sel == '0) ? '0 : lat_sel - 1'b1;
    wire [PTR_W-1:0] launch_entry = launch_wr ? wr_ptr : rd_ptr;

    // The access is placed latency-1 slots deep and reaches slot 0 after that many edges.
    always_comb begin
        for (int i = 0; i < LAT_MAX; i++) begin
            next_pipe_type[i] = (i + 1 < LAT_MAX) ? pipe_type[(i + 1) % LAT_MAX] : MTC_XFER_NONE;
            next_pipe_entry[i] = (i + 1 < LAT_MAX) ? pipe_entry[(i + 1) % LAT_MAX] : PTR_FIRST;
            if (launch && (LAT_W'(i) == lat_slot)) begin
                next_pipe_type[i] = held_type;
                next_pipe_entry[i] = launch_entry;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pipe_type <= '{default: MTC_XFER_NONE};
            pipe_entry <= '{default: PTR_FIRST};
        end else begin
            pipe_type <= next_pipe_type;
            pipe_entry <= next_pipe_entry;
        end
    end

    // ----------------------------------------------------------------
    // Burst engine
    // ----------------------------------------------------------------
    logic busy, pend_valid;
    logic [1:0] cur_type, pend_type;
    logic [PTR_W-1:0] cur_entry, pend_entry;
    logic [BEAT_W-1:0] beat;
    logic [MEM_W-1:0] buf_mem [BUF_ENTRIES*BURST_LEN];
    logic buf_in_ready;

    wire due = (pipe_type[0] != MTC_XFER_NONE);
    wire is_write = busy && (cur_type == MTC_XFER_WR);
    wire is_read = busy && (cur_type != MTC_XFER_WR);
    wire beat_go = is_write || (is_read && buf_in_ready);
    wire burst_end = beat_go && (beat == BEAT_LAST);
    wire can_start = !busy || burst_end;
    wire start = can_start && (pend_valid || due);
    wire [1:0] start_type = pend_valid ? pend_type : pipe_type[0];
    wire [PTR_W-1:0] start_entry = pend_valid ? pend_entry : pipe_entry[0];
    wire pat_bit = beat[BEAT_W-1] ? pattern_register_high[beat[2:0]] : pattern_register_low[beat[2:0]];
    wire [MEM_W-1:0] stored = buf_mem[mem_index(cur_entry, beat)];
    wire mask_drive = wr_bus_inversion_en || rd_bus_inversion_en || data_masking_en;
    // Pattern beats also appear on the mask lines, with no inversion function applied.
    wire [WORD_W-1:0] rd_word = (cur_type == MTC_XFER_RD) ? {mask_drive, stored}
                                : {1'b1, {MASK_W{pat_bit}}, {DATA_W{pat_bit}} ^ invert_mask};

    assign wr_beat_take = is_write;

    // A burst that is stalled by the receiver holds a later due access in a one-deep slot.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy <= 1'b0;
            cur_type <= MTC_XFER_NONE;
            cur_entry <= PTR_FIRST;
            beat <= '0;
            pend_valid <= 1'b0;
            pend_type <= MTC_XFER_NONE;
            pend_entry <= PTR_FIRST;
        end else begin
            if (start) begin
                busy <= 1'b1;
                cur_type <= start_type;
                cur_entry <= start_entry;
                beat <= '0;
            end else if (burst_end) begin
                busy <= 1'b0;
            end else if (beat_go) begin
                beat <= beat + 1'b1;
            end
            if (due && !(can_start && !pend_valid)) begin
                pend_valid <= 1'b1;
                pend_type <= pipe_type[0];
                pend_entry <= pipe_entry[0];
            end else if (start && pend_valid) begin
                pend_valid <= 1'b0;
            end
        end
    end

    // Write beats land in the entry chosen at launch; no reset so it maps to plain storage.
    always_ff @(posedge clk) begin
        if (is_write) begin
            buf_mem[mem_index(cur_entry, beat)] <= {wr_mask, wr_beat};
        end
    end

    // ----------------------------------------------------------------
    // Two-entry output buffer
    // ----------------------------------------------------------------
    logic [WORD_W-1:0] obuf [2];
    logic owp, orp;
    logic [1:0] ocount;
    wire opush = is_read && buf_in_ready;
    wire opop = rd_valid && rd_ready;

    assign buf_in_ready = (ocount != 2'h2);
    assign rd_valid = (ocount != 2'h0);
    assign {rd_mask_oe, rd_mask, rd_data} = obuf[orp];

    // Receiver stalls back up into the burst engine instead of dropping beats.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            obuf <= '{default: '0};
            owp <= 1'b0;
            orp <= 1'b0;
            ocount <= 2'h0;
        end else begin
            if (opush) begin
                obuf[owp] <= rd_word;
                owp <= ~owp;
            end
            if (opop) begin
                orp <= ~orp;
            end
            ocount <= ocount + {1'b0, opush} - {1'b0, opop};
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    osc_start_decode_a: assert property (dec_osc_go |=> osc_start ##1 !osc_start)
        else $error("oscillator start pulse wrong");
    nop_low_bit_a: assert property (nop_seen |-> !$past(arg_bit6) && $past(state) == MTC_ARG)
        else $error("no-operation decoded with bit 6 set");
    launch_after_cas_a: assert property (launch |-> $past(state == MTC_CAS_A && cas_first))
        else $error("launch without column command");
    wr_ptr_wrap_a: assert property (launch_wr && wr_ptr == PTR_LAST && !ptr_clear |=> wr_ptr == PTR_FIRST)
        else $error("write pointer did not wrap");
    rd_ptr_wrap_a: assert property (launch_rd && rd_ptr == PTR_LAST && !ptr_clear |=> rd_ptr == PTR_FIRST)
        else $error("read pointer did not wrap");
    write_burst_len_a: assert property (start && start_type == MTC_XFER_WR |=> wr_beat_take[*8] ##1 wr_beat_take[*8])
        else $error("write burst not sixteen beats");
    reserved_quiet_a: assert property (dec_reserved && !ptr_clear |=> $stable(wr_ptr) && $stable(rd_ptr) && state == MTC_IDLE)
        else $error("reserved code changed state");
    mask_drive_a: assert property (opush && cur_type == MTC_XFER_RD |=> obuf[$past(owp)][WORD_W-1] == $past(mask_drive))
        else $error("mask drive flag wrong");
    out_buf_bound_a: assert property (ocount <= 2'h2 && !(ocount == 2'h2 && opush))
        else $error("output buffer overflow");
    second_part_a: assert property (dec_osc_end || dec_imp_go || dec_imp_end |=> state == MTC_IDLE)
        else $error("non-array function waited for column command");

endmodule : mtc_training_cmd

// ==== bench/mtc_ctl_model.sv ====
// Controller model that issues multi-purpose commands on the pins.
`timescale 1ns/10ps
module mtc_ctl_model import mtc_pkg::*; (
    input wire logic clk, // Clock.
    output logic cs_pin = 1'b0, // Chip select.
    output logic [CAL_W-1:0] cmd_addr_lines = '0 // Command lines.
);
    // Two-edge command, then at once the column command for array functions.
    task automatic send(input logic [6:0] arg, input bit col);
        @(posedge clk) #1;
        cs_pin = 1'b1;
        cmd_addr_lines = {arg[6], FIRST_EDGE_CODE};
        @(posedge clk) #1;
        cs_pin = 1'b0;
        cmd_addr_lines = arg[5:0];
        if (col) begin
            @(posedge clk) #1;
            cs_pin = 1'b1;
            cmd_addr_lines = {1'b0, CAS2_FIRST_CODE};
            @(posedge clk) #1;
            cs_pin = 1'b0;
            cmd_addr_lines = '0;
        end
        // Deselected lines must not keep showing the last value.
        @(posedge clk) #1 cmd_addr_lines = ~cmd_addr_lines;
    endtask : send
endmodule : mtc_ctl_model

// ==== bench/tb_top.sv ====
// Self-checking bench for the training command block.
`timescale 1ns/10ps
module tb_top;
    import mtc_pkg::*;
    localparam logic [7:0] PLO = 8'ha5;
    localparam logic [7:0] PHI = 8'h3c;
    localparam logic [15:0] INV = 16'h00ff;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic rd_ready = 1'b1;
    logic ptr_disturb = 1'b0;
    logic [1:0] wr_mask = '0;
    logic cs_pin, wr_beat_take, rd_valid, rd_mask_oe;
    logic [CAL_W-1:0] cmd_addr_lines;
    logic [15:0] rd_data;
    logic [15:0] wr_beat = '0;
    logic [1:0] rd_mask;
    wire [5:0] pulses;
    logic [7:0] wb = '0;
    logic [7:0] nb = '0;
    logic [18:0] q[$];
    int errors = 0;
    int n_tests = 0;
    mtc_ctl_model i_ctl (.clk(clk), .cs_pin(cs_pin), .cmd_addr_lines(cmd_addr_lines));
    mtc_training_cmd i_dut (.clk(clk), .rstn(rstn), .cs_pin(cs_pin), .cmd_addr_lines(cmd_addr_lines),
        .cke_pin(1'b1), .ptr_disturb(ptr_disturb), .write_latency(5'h03), .read_latency(5'h03),
        .wr_bus_inversion_en(1'b0), .rd_bus_inversion_en(1'b0), .data_masking_en(rstn),
        .pattern_register_low(PLO), .pattern_register_high(PHI), .invert_mask(INV),
        .wr_beat(wr_beat), .wr_mask(wr_mask), .wr_beat_take(wr_beat_take), .rd_valid(rd_valid),
        .rd_ready(rd_ready), .rd_data(rd_data), .rd_mask(rd_mask), .rd_mask_oe(rd_mask_oe),
        .osc_start(pulses[5]), .osc_stop(pulses[4]), .impedance_cal_start(pulses[3]),
        .impedance_cal_latch(pulses[2]), .nop_seen(pulses[1]), .reserved_seen(pulses[0]));
    initial begin
        forever #4 clk = ~clk;
    end
    // Collect read beats; a half-rate receiver keeps the read buffer stalling.
    always @(posedge clk) begin
        if (rd_valid === 1'b1 && rd_ready === 1'b1) q.push_back({rd_mask_oe, rd_mask, rd_data});
        if (wr_beat_take === 1'b1) nb = nb + 8'h01;
        #1 wr_beat = {wb, nb};
        // The mask follows the beat off the edge, so the block never races the count.
        wr_mask = nb[1:0];
        rd_ready = ~rd_ready;
    end
    task automatic chk(input string nm, input logic [18:0] seen, input logic [18:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic t_pulses;
        logic [6:0] c[8] = '{ARG_OSC_START, ARG_OSC_STOP, ARG_IMP_START, ARG_IMP_LATCH,
            7'h2a, 7'h45, 7'h49, 7'h7f};
        for (int i = 0; i < 8; i++) begin
            i_ctl.send(c[i], 1'b0);
            repeat (2) @(posedge clk);
            #1 chk("pulse", 19'(pulses), 19'(i < 5 ? 6'h20 >> i : 6'h01));
            @(posedge clk) #1 chk("pulse end", 19'(pulses), '0);
        end
    endtask : t_pulses
    // Six writes: the sixth lands on the first entry.
    task automatic t_write;
        for (int w = 1; w <= 6; w++) begin
            i_ctl.send(ARG_BUF_WRITE, 1'b1);
            wb = 8'(w);
            nb = '0;
            repeat (30) @(posedge clk);
            #2 chk("beats", 19'(nb), 19'(16));
        end
    endtask : t_write
    task automatic t_read(input int n);
        for (int r = 0; r < n; r++) begin
            q.delete();
            i_ctl.send(ARG_BUF_READ, 1'b1);
            repeat (50) @(posedge clk);
            chk("rd count", 19'(q.size()), 19'(16));
            for (int b = 0; b < 16; b++)
                chk("rd beat", q.pop_front(), {1'b1, 2'(b), 8'(r % 5 == 0 ? 6 : r % 5 + 1), 8'(b)});
        end
    endtask : t_read
    task automatic t_pattern;
        logic b;
        q.delete();
        i_ctl.send(ARG_PATTERN_CAL, 1'b1);
        repeat (50) @(posedge clk);
        chk("pat count", 19'(q.size()), 19'(16));
        for (int i = 0; i < 16; i++) begin
            b = i < 8 ? PLO[i] : PHI[i-8];
            chk("pattern", q.pop_front(), {1'b1, {2{b}}, {16{b}} ^ INV});
        end
    endtask : t_pattern
    // An ordinary access pulse sends both pointers back to the first entry.
    task automatic t_disturb;
        @(posedge clk) #1 ptr_disturb = 1'b1;
        @(posedge clk) #1 ptr_disturb = 1'b0;
        repeat (20) @(posedge clk);
    endtask : t_disturb
    task automatic summarize;
        if (errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize
    initial begin
        repeat (5) @(posedge clk);
        #1 rstn = 1'b1;
        t_pulses();
        t_write();
        t_read(6);
        t_pattern();
        t_read(1);
        t_disturb();
        t_read(1);
        summarize();
    end
    // Watchdog well beyond the roughly 6 us the tests need.
    initial begin
        #60000;
        errors++;
        summarize();
    end
endmodule : tb_top
